// file: flag_copy_pkg.sv
// constants, register map and carrier types for the flag copy / pointer load executor
//
// Overview of operation
// RULE1 - flag copy writes flags bits 7..0 into accumulator high byte, masked with 0x00FF.
// RULE2 - accumulator high byte then holds carry 0, parity 2, aux 4, zero 6, sign 7.
// RULE3 - none of the three instructions alter any status flag bit.
// RULE4 - pointer load: word at address to destination, word at address plus 2 to data segment.
// RULE5 - pointer load is opcode C5 with memory ModRM; 18 clocks word bus, 26 byte bus.
// RULE6 - offset load writes the operand's effective offset to the register, no memory access.
// RULE7 - offset load is opcode 8D with ModRM; 6 clocks on both bus variants.
// RULE8 - flag copy is single byte opcode 9F; 2 clocks on both bus variants.
// RULE9 - byte bus fetches pointer as four byte reads, offset then segment, before any update.
package flag_copy_pkg;

  // register byte addresses
  localparam logic [7:0]  OFF_FLAGS     = 8'h00;
  localparam logic [7:0]  OFF_DSEG      = 8'h08;
  localparam logic [7:0]  OFF_CTRL      = 8'h0C;
  localparam logic [7:0]  OFF_INSTR     = 8'h10;
  localparam logic [7:0]  OFF_DISP      = 8'h14;
  localparam logic [7:0]  OFF_STATUS    = 8'h18;
  localparam logic [2:0]  OFF_GPR_PAGE  = 3'h1;   // haddr[7:5]; gpr n at 0x20 + 4n

  // reset values
  localparam logic [15:0] FLAGS_RESET   = 16'h0000;
  localparam logic [15:0] DSEG_RESET    = 16'h0000;
  localparam logic [15:0] GPR_RESET     = 16'h0000;

  // flags layout
  localparam logic [15:0] FLAGS_WR_MASK = 16'h0FD5; // reserved bits stay zero
  localparam logic [15:0] FLAGS_LOW_MASK = 16'h00FF;
  localparam int          CARRY_FLAG_BIT = 0;
  localparam int          PARITY_FLAG_BIT = 2;
  localparam int          AUX_CARRY_FLAG_BIT = 4;
  localparam int          ZERO_FLAG_BIT = 6;
  localparam int          SIGN_FLAG_BIT = 7;

  // status / control fields
  localparam int          ST_BUSY_BIT   = 0;
  localparam int          ST_DONE_BIT   = 1;
  localparam int          ST_ILLEGAL_BIT = 2;
  localparam int          CTRL_BYTEBUS_BIT = 0;

  // opcodes
  localparam logic [7:0]  OP_FLAGS_TO_ACC_HIGH_COPY    = 8'h9F;
  localparam logic [7:0]  OP_FAR_POINTER_LOAD_DATASEG  = 8'hC5;
  localparam logic [7:0]  OP_EFFECTIVE_OFFSET_LOAD     = 8'h8D;
  localparam logic [1:0]  MOD_REGISTER  = 2'h3;

  // instruction clock counts
  localparam logic [5:0]  CLK_FLAG_COPY    = 6'h02;
  localparam logic [5:0]  CLK_OFFSET_LOAD  = 6'h06;
  localparam logic [5:0]  CLK_PTR_WORDBUS  = 6'h12;
  localparam logic [5:0]  CLK_PTR_BYTEBUS  = 6'h1A;

  // pointer layout
  localparam logic [15:0] PTR_SEG_OFS   = 16'h0002;

  // register file indices
  localparam logic [2:0]  REG_ACC = 3'h0;
  localparam logic [2:0]  REG_BX  = 3'h3;
  localparam logic [2:0]  REG_BP  = 3'h5;
  localparam logic [2:0]  REG_SI  = 3'h6;
  localparam logic [2:0]  REG_DI  = 3'h7;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC
  } exec_state_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] regSel;
    logic [2:0] rm;
  } modrm_t;

  typedef struct packed {
    logic        valid;
    logic        wide;
    logic [19:0] addr;
  } mem_req_t;

endpackage

// file: flag_copy_pointer_load_ops.sv
// executor for flag copy, far pointer load and effective offset load, with AHB-Lite register slave
`timescale 1ns/1ps
module flag_copy_pointer_load_ops
  import flag_copy_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output mem_req_t         memReq,
  input  wire logic [15:0] memRdata,
  input  wire logic        memAck
);

  logic [15:0]       flags_reg,   flags_next;
  logic [15:0]       dseg_reg,    dseg_next;
  logic [7:0][15:0]  gpr_reg,     gpr_next;
  logic              byteBus_reg, byteBus_next;
  logic [15:0]       instr_reg,   instr_next;
  logic [15:0]       disp_reg,    disp_next;
  logic              done_reg,    done_next;
  logic              illegal_reg, illegal_next;
  logic [5:0]        cycles_reg,  cycles_next;
  exec_state_t       state_reg,   state_next;
  logic [5:0]        cnt_reg,     cnt_next;
  logic [5:0]        target_reg,  target_next;
  logic [15:0]       ea_reg,      ea_next;
  logic [31:0]       ptr_reg,     ptr_next;
  logic [1:0]        fIdx_reg,    fIdx_next;
  logic              fetched_reg, fetched_next;
  mem_req_t          memReq_reg,  memReq_next;
  logic              wrPend_reg,  wrPend_next;
  logic [7:0]        wrAddr_reg,  wrAddr_next;
  logic [31:0]       hrdata_reg,  hrdata_next;

  logic              busy;
  logic              addrPhase;
  modrm_t            startModrm;
  logic [7:0]        startOp;

  // effective offset of a memory operand from mod/rm, base registers and displacement
  function automatic logic [15:0] calcEa(input modrm_t m, input logic [15:0] disp,
                                         input logic [7:0][15:0] r);
    logic [15:0] base;
    logic [15:0] dispVal;
    base = 16'h0000;
    dispVal = 16'h0000;
    case (m.rm)
      3'h0:    base = r[REG_BX] + r[REG_SI];
      3'h1:    base = r[REG_BX] + r[REG_DI];
      3'h2:    base = r[REG_BP] + r[REG_SI];
      3'h3:    base = r[REG_BP] + r[REG_DI];
      3'h4:    base = r[REG_SI];
      3'h5:    base = r[REG_DI];
      3'h6:    base = (m.mode == 2'h0) ? 16'h0000 : r[REG_BP];
      default: base = r[REG_BX];
    endcase
    case (m.mode)
      2'h0:    dispVal = (m.rm == 3'h6) ? disp : 16'h0000; // direct address form
      2'h1:    dispVal = {{8{disp[7]}}, disp[7:0]};
      2'h2:    dispVal = disp;
      default: dispVal = 16'h0000;
    endcase
    return base + dispVal;
  endfunction

  // segment:offset to a 20-bit physical address
  function automatic logic [19:0] physAddr(input logic [15:0] seg, input logic [15:0] ofs);
    return {seg, 4'h0} + {4'h0, ofs};
  endfunction

  // register read view; unmapped words read zero
  function automatic logic [31:0] readReg(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a[7:5] == OFF_GPR_PAGE) begin
      d = {16'h0000, gpr_reg[a[4:2]]};
    end else begin
      case (a)
        OFF_FLAGS:  d = {16'h0000, flags_reg};
        OFF_DSEG:   d = {16'h0000, dseg_reg};
        OFF_CTRL:   d = {31'h0000_0000, byteBus_reg};
        OFF_INSTR:  d = {16'h0000, instr_reg};
        OFF_DISP:   d = {16'h0000, disp_reg};
        OFF_STATUS: d = {18'h0_0000, cycles_reg, 5'h00, illegal_reg, done_reg, busy};
        default:    d = 32'h0000_0000;
      endcase
    end
    return d;
  endfunction

  assign busy       = (state_reg == ST_EXEC);
  assign addrPhase  = hsel && hready && htrans[1];
  assign startOp    = hwdata[7:0];
  assign startModrm = modrm_t'(hwdata[15:8]);

  // bus slave: zero wait states, read data registered at the address phase edge
  always_comb begin
    wrPend_next = addrPhase && hwrite;
    wrAddr_next = addrPhase ? {haddr[7:2], 2'h0} : wrAddr_reg;
    hrdata_next = hrdata_reg;
    if (addrPhase && !hwrite) begin
      hrdata_next = readReg({haddr[7:2], 2'h0});
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      wrPend_reg <= wrPend_next;
      wrAddr_reg <= wrAddr_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // register writes, instruction start and execution sequencing
  always_comb begin
    flags_next   = flags_reg;
    dseg_next    = dseg_reg;
    gpr_next     = gpr_reg;
    byteBus_next = byteBus_reg;
    instr_next   = instr_reg;
    disp_next    = disp_reg;
    done_next    = done_reg;
    illegal_next = illegal_reg;
    cycles_next  = cycles_reg;
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    target_next  = target_reg;
    ea_next      = ea_reg;
    ptr_next     = ptr_reg;
    fIdx_next    = fIdx_reg;
    fetched_next = fetched_reg;
    memReq_next  = memReq_reg;

    // software may not disturb architectural state mid-instruction
    if (wrPend_reg) begin
      if (wrAddr_reg[7:5] == OFF_GPR_PAGE) begin
        if (!busy) begin
          gpr_next[wrAddr_reg[4:2]] = hwdata[15:0];
        end
      end else begin
        case (wrAddr_reg)
          OFF_FLAGS:  if (!busy) flags_next = hwdata[15:0] & FLAGS_WR_MASK;
          OFF_DSEG:   if (!busy) dseg_next = hwdata[15:0];
          OFF_CTRL:   if (!busy) byteBus_next = hwdata[CTRL_BYTEBUS_BIT];
          OFF_DISP:   if (!busy) disp_next = hwdata[15:0];
          OFF_STATUS: begin
            done_next    = done_reg & ~hwdata[ST_DONE_BIT];
            illegal_next = illegal_reg & ~hwdata[ST_ILLEGAL_BIT];
          end
          OFF_INSTR: begin
            if (!busy) begin
              instr_next = hwdata[15:0];
              ptr_next   = 32'h0000_0000;
              fIdx_next  = 2'h0;
              ea_next    = calcEa(startModrm, disp_reg, gpr_reg);
              cnt_next   = 6'h01;
              case (startOp)
                OP_FLAGS_TO_ACC_HIGH_COPY: begin                     // [RULE8]
                  state_next   = ST_EXEC;
                  target_next  = CLK_FLAG_COPY;                      // [RULE8]
                  fetched_next = 1'b1;
                end
                OP_EFFECTIVE_OFFSET_LOAD: begin                      // [RULE7]
                  if (startModrm.mode == MOD_REGISTER) begin
                    illegal_next = 1'b1;
                  end else begin
                    state_next   = ST_EXEC;
                    target_next  = CLK_OFFSET_LOAD;                  // [RULE7]
                    fetched_next = 1'b1;                             // no operand access [RULE6]
                  end
                end
                OP_FAR_POINTER_LOAD_DATASEG: begin                   // [RULE5]
                  if (startModrm.mode == MOD_REGISTER) begin
                    illegal_next = 1'b1;                             // pointer must be in memory [RULE5]
                  end else begin
                    state_next   = ST_EXEC;
                    target_next  = byteBus_reg ? CLK_PTR_BYTEBUS : CLK_PTR_WORDBUS; // [RULE5]
                    fetched_next = 1'b0;
                    memReq_next.valid = 1'b1;
                    memReq_next.wide  = !byteBus_reg;
                    memReq_next.addr  = physAddr(dseg_reg, calcEa(startModrm, disp_reg, gpr_reg));
                  end
                end
                default: illegal_next = 1'b1;
              endcase
            end
          end
          default: ;
        endcase
      end
    end

    // operand fetch: offset word first, then segment word; bytes ascend on the byte bus
    if (busy && memReq_reg.valid && memAck) begin
      if (memReq_reg.wide) begin
        ptr_next[{fIdx_reg[0], 4'h0} +: 16] = memRdata;
      end else begin
        ptr_next[{fIdx_reg, 3'h0} +: 8] = memRdata[7:0];           // [RULE9]
      end
      if ((memReq_reg.wide && fIdx_reg == 2'h1) || fIdx_reg == 2'h3) begin
        memReq_next.valid = 1'b0;
        fetched_next      = 1'b1;
      end else begin
        fIdx_next = fIdx_reg + 2'h1;
        if (memReq_reg.wide) begin
          memReq_next.addr = physAddr(dseg_reg, ea_reg + PTR_SEG_OFS); // [RULE4]
        end else begin
          memReq_next.addr = physAddr(dseg_reg, ea_reg + {14'h0000, fIdx_next}); // [RULE9]
        end
      end
    end

    // commit once the clock count has run and every operand byte is in
    if (busy) begin
      if (cnt_reg >= target_reg && fetched_reg) begin
        state_next  = ST_IDLE;
        done_next   = 1'b1;                                          // set beats a same-cycle clear
        cycles_next = cnt_reg;
        case (instr_reg[7:0])
          OP_FLAGS_TO_ACC_HIGH_COPY: begin
            gpr_next[REG_ACC][15:8] = flags_reg[7:0] & FLAGS_LOW_MASK[7:0]; // [RULE1] [RULE2]
          end
          OP_EFFECTIVE_OFFSET_LOAD: begin
            gpr_next[instr_reg[13:11]] = ea_reg;                     // [RULE6]
          end
          OP_FAR_POINTER_LOAD_DATASEG: begin
            gpr_next[instr_reg[13:11]] = ptr_reg[15:0];              // [RULE4] [RULE9]
            dseg_next                  = ptr_reg[31:16];             // [RULE4]
          end
          default: ;
        endcase
        // flags_next left untouched on every path above [RULE3]
      end else if (cnt_reg != 6'h3F) begin
        cnt_next = cnt_reg + 6'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      flags_reg   <= FLAGS_RESET;
      dseg_reg    <= DSEG_RESET;
      for (int i = 0; i < 8; i++) begin
        gpr_reg[i] <= GPR_RESET;
      end
      byteBus_reg <= 1'b0;
      instr_reg   <= 16'h0000;
      disp_reg    <= 16'h0000;
      done_reg    <= 1'b0;
      illegal_reg <= 1'b0;
      cycles_reg  <= 6'h00;
      state_reg   <= ST_IDLE;
      cnt_reg     <= 6'h00;
      target_reg  <= 6'h00;
      ea_reg      <= 16'h0000;
      ptr_reg     <= 32'h0000_0000;
      fIdx_reg    <= 2'h0;
      fetched_reg <= 1'b0;
      memReq_reg  <= '0;
    end else begin
      flags_reg   <= flags_next;
      dseg_reg    <= dseg_next;
      gpr_reg     <= gpr_next;
      byteBus_reg <= byteBus_next;
      instr_reg   <= instr_next;
      disp_reg    <= disp_next;
      done_reg    <= done_next;
      illegal_reg <= illegal_next;
      cycles_reg  <= cycles_next;
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      target_reg  <= target_next;
      ea_reg      <= ea_next;
      ptr_reg     <= ptr_next;
      fIdx_reg    <= fIdx_next;
      fetched_reg <= fetched_next;
      memReq_reg  <= memReq_next;
    end
  end

  // slave never stalls and never errors
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign hrdata = hrdata_reg;
  assign memReq = memReq_reg;

endmodule

// file: flag_copy_asserts.sv
// concurrent checks on the executor's bus and operand-read ports
`timescale 1ns/1ps
module flag_copy_asserts
  import flag_copy_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire mem_req_t    memReq,
  input wire logic [15:0] memRdata,
  input wire logic        memAck
);
  logic instrWr_reg;
  logic instrWr_next;
  logic startCopy;
  logic startLea;
  logic startPtr;

  // an instruction write is only known once its data phase arrives
  always_comb instrWr_next = rstn && hsel && hready && htrans[1] && hwrite && haddr[7:2] == OFF_INSTR[7:2];
  always_ff @(posedge ref_clk) instrWr_reg <= instrWr_next;

  // register-form ModRM is refused for the offset and pointer loads, so it starts nothing
  assign startCopy = instrWr_reg && hwdata[7:0] == OP_FLAGS_TO_ACC_HIGH_COPY;
  assign startLea  = instrWr_reg && hwdata[7:0] == OP_EFFECTIVE_OFFSET_LOAD && hwdata[15:14] != MOD_REGISTER;
  assign startPtr  = instrWr_reg && hwdata[7:0] == OP_FAR_POINTER_LOAD_DATASEG && hwdata[15:14] != MOD_REGISTER;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_reset_idle: assert property (@(posedge ref_clk) disable iff (1'b0)
    !rstn |=> !memReq.valid && hrdata == 32'h0) else $error("outputs not idle after reset");
  a_ptr_start: assert property (startPtr |=> memReq.valid) else $error("pointer load issued no read");
  a_ptr_finish: assert property (startPtr |-> ##[2:60] !memReq.valid) else $error("pointer reads never end");
  a_req_held: assert property (memReq.valid && !memAck |=> memReq.valid && $stable(memReq.addr)) else $error("req dropped");
  a_word_step: assert property (memReq.valid && memAck && memReq.wide
    |=> !memReq.valid || memReq.addr == $past(memReq.addr) + 20'h2) else $error("segment word address wrong");
  a_byte_step: assert property (memReq.valid && memAck && !memReq.wide
    |=> !memReq.valid || memReq.addr == $past(memReq.addr) + 20'h1) else $error("byte read order wrong");
  a_lea_nomem: assert property (startLea |-> !memReq.valid [*7]) else $error("offset load touched memory");
  a_copy_nomem: assert property (startCopy |-> !memReq.valid [*3]) else $error("flag copy touched memory");

  cover property (startPtr);
  cover property (startLea);
  cover property (startCopy);
  cover property (memAck && !memReq.wide);
endmodule

// file: flag_copy_pointer_load_ops_tb_top.sv
// self-checking bench for the flag copy, pointer load and offset load executor
`timescale 1ns/1ps
module flag_copy_pointer_load_ops_tb_top
  import flag_copy_pkg::*;
;
  typedef struct { logic [31:0] v; logic [31:0] m; string nm; } note_t;
  logic        ref_clk = 0, rstn = 0, hsel = 0, hwrite = 0, memAck = 0, slowMode = 0, rdPhase = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [15:0] memRdata = 0, dseg = 0, flg = 0;
  logic [15:0] gpr[8];
  logic        hreadyout, hresp;
  mem_req_t    memReq;
  note_t       notes[$];
  int          errors = 0, n_compared = 0, seed = 6;

  always #10 ref_clk = ~ref_clk;

  flag_copy_pointer_load_ops flag_copy_pointer_load_ops_inst (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .memReq(memReq), .memRdata(memRdata), .memAck(memAck));

  // operand memory: each byte hashes its address so swapped words show up
  function automatic logic [7:0] mb(input logic [19:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  function automatic logic [19:0] pa(input logic [15:0] o);
    return {dseg, 4'h0} + {4'h0, o};
  endfunction
  // answers a request a cycle late, or randomly stalled; data moves when not answering
  always @(posedge ref_clk) begin
    if (memReq.valid && !memAck && (!slowMode || ($random(seed) & 3) == 0)) begin
      memAck <= 1'b1;
      memRdata <= {memReq.wide ? mb(memReq.addr + 20'h1) : ~mb(memReq.addr), mb(memReq.addr)};
    end else begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
    end
  end

  task automatic print_verdict;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // watcher: read data is compared at the edge that closes the data phase
  always @(posedge ref_clk) if (rdPhase) begin
    note_t n;
    n = notes.pop_front();
    check(n.nm, n.v & n.m, hrdata & n.m);
  end

  task automatic hedge;
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1 && n < 50) begin
      n++;
      @(posedge ref_clk);
    end
    if (n >= 50) begin
      errors++;
      print_verdict();
    end
  endtask
  // one single AHB transfer: address phase, then data phase
  task automatic bus(input logic [7:0] a, input logic w, input logic c, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    hedge();
    htrans <= 2'b00;
    hwdata <= w ? d : ~hwdata;
    rdPhase <= c;
    hedge();
    rdPhase <= 1'b0;
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, 1'b0, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string nm);
    logic [31:0] q;
    notes.push_back('{e, m, nm});
    bus(a, 1'b0, 1'b1, 32'h0, q);
  endtask
  // start an instruction, poll for done, check the status word, clear it
  task automatic exec(input logic [7:0] op, input logic [7:0] mr, input logic [5:0] cyc, input logic [31:0] m);
    logic [31:0] q;
    int n;
    wr(OFF_INSTR, {16'h0, mr, op});
    if (slowMode) wr(OFF_FLAGS, ~{16'h0, flg}); // busy, so this must be dropped
    n = 0;
    do begin
      bus(OFF_STATUS, 1'b0, 1'b0, 32'h0, q);
      n++;
    end while (q[ST_DONE_BIT] !== 1'b1 && n < 100);
    if (n >= 100) begin
      errors++;
      print_verdict();
    end
    // cycle count sits in status bits 13..8, done in bit 1
    rd(OFF_STATUS, {18'h0, cyc, 8'h02}, m, "status");
    wr(OFF_STATUS, 32'h6);
  endtask
  function automatic logic [15:0] ea(input logic [1:0] md, input logic [2:0] rm, input logic [15:0] dp);
    logic [15:0] b;
    case (rm)
      3'h0: b = gpr[REG_BX] + gpr[REG_SI];
      3'h1: b = gpr[REG_BX] + gpr[REG_DI];
      3'h2: b = gpr[REG_BP] + gpr[REG_SI];
      3'h3: b = gpr[REG_BP] + gpr[REG_DI];
      3'h4: b = gpr[REG_SI];
      3'h5: b = gpr[REG_DI];
      3'h6: b = gpr[REG_BP];
      default: b = gpr[REG_BX];
    endcase
    if (md == 2'h0) return (rm == 3'h6) ? dp : b;
    return b + ((md == 2'h1) ? {{8{dp[7]}}, dp[7:0]} : dp);
  endfunction

  initial begin
    logic [15:0] v, d;
    logic [7:0]  mr;
    logic [7:0]  ops[3];
    ops = '{OP_FAR_POINTER_LOAD_DATASEG, OP_EFFECTIVE_OFFSET_LOAD, 8'h9E};
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    // reset values, and a hole in the map reads zero
    foreach (ops[i]) rd(8'h00 + 8'(8 * i), 32'h0, '1, "reset value");
    rd(8'h1C, 32'h0, '1, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      gpr[i] = 16'($random(seed));
      wr({3'h1, 3'(i), 2'h0}, {16'h0, gpr[i]});
    end
    for (int i = 0; i < 4; i++) begin
      flg = (i == 0) ? 16'hFFFF : 16'($random(seed));
      wr(OFF_FLAGS, {16'h0, flg});
      flg = flg & FLAGS_WR_MASK;
      exec(OP_FLAGS_TO_ACC_HIGH_COPY, 8'h00, CLK_FLAG_COPY, 32'h3F07);
      gpr[REG_ACC][15:8] = flg[7:0];
      rd(8'h20, {16'h0, gpr[REG_ACC]}, '1, "acc");
      rd(OFF_FLAGS, {16'h0, flg}, '1, "flags");
    end
    $display("test flag copy done");
    // every base form but BP alone (rm 6 runs only as the direct form), and every displacement mode
    for (int i = 0; i < 12; i++) begin
      mr = {2'(i % 3), 3'($random(seed)), 3'(i)};
      d = 16'($random(seed));
      wr(OFF_DISP, {16'h0, d});
      v = ea(mr[7:6], mr[2:0], d);
      exec(OP_EFFECTIVE_OFFSET_LOAD, mr, CLK_OFFSET_LOAD, 32'h3F07);
      gpr[mr[5:3]] = v;
      rd({3'h1, mr[5:3], 2'h0}, {16'h0, v}, '1, "offset dest");
    end
    rd(OFF_FLAGS, {16'h0, flg}, '1, "flags");
    $display("test offset load done");
    // word and byte bus, prompt then stalled operand reads
    for (int i = 0; i < 6; i++) begin
      slowMode = i > 3;
      wr(OFF_CTRL, {31'h0, i[0]});
      mr = {2'(i % 3), 3'($random(seed)), 3'(i + 3)};
      d = 16'($random(seed));
      wr(OFF_DISP, {16'h0, d});
      dseg = 16'($random(seed));
      wr(OFF_DSEG, {16'h0, dseg});
      v = ea(mr[7:6], mr[2:0], d);
      exec(OP_FAR_POINTER_LOAD_DATASEG, mr, i[0] ? CLK_PTR_BYTEBUS : CLK_PTR_WORDBUS, slowMode ? 32'h7 : 32'h3F07);
      d = {mb(pa(v + 16'h3)), mb(pa(v + 16'h2))};
      gpr[mr[5:3]] = {mb(pa(v + 16'h1)), mb(pa(v))};
      dseg = d;
      rd({3'h1, mr[5:3], 2'h0}, {16'h0, gpr[mr[5:3]]}, '1, "pointer offset");
      rd(OFF_DSEG, {16'h0, dseg}, '1, "pointer segment");
    end
    rd(OFF_FLAGS, {16'h0, flg}, '1, "flags");
    $display("test pointer load done");
    // register-form operands and an unknown opcode are refused
    foreach (ops[i]) begin
      wr(OFF_INSTR, {16'h0, 8'hC0, ops[i]});
      @(posedge ref_clk);
      rd(OFF_STATUS, 32'h4, 32'h7, "refused");
      wr(OFF_STATUS, 32'h6);
    end
    rd(8'h20, {16'h0, gpr[REG_ACC]}, '1, "acc kept");
    $display("test refusals done");
    @(posedge ref_clk);
    print_verdict();
  end
endmodule

bind flag_copy_pointer_load_ops flag_copy_asserts flag_copy_asserts_inst (.ref_clk(ref_clk), .rstn(rstn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .memReq(memReq), .memRdata(memRdata), .memAck(memAck));
